// File: pkg/aux_control_pkg.sv
package aux_control_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] aux_control_off   = 8'h8E;
  localparam logic [7:0] aux_control_reset = 8'h0C;
  localparam logic [7:0] aux_control_wmask = 8'hAF;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int strobe_suppress_bit       = 0;
  localparam int external_data_select_bit  = 1;
  localparam int xram_size_lo_bit          = 2;
  localparam int xram_size_hi_bit          = 3;
  localparam int strobe_stretch_select_bit = 5;
  localparam int pullup_disable_bit        = 7;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam logic [2:0] ale_div_x1     = 3'h6;
  localparam logic [2:0] ale_div_x2     = 3'h3;
  localparam logic [2:0] rdwr_len_long  = 3'h6;
  localparam logic [2:0] rdwr_len_short = 3'h3;

  // ****************************************************************
  // Expanded RAM limits, last usable address
  // ****************************************************************
  localparam logic [9:0] xram_top_256  = 10'h0FF;
  localparam logic [9:0] xram_top_512  = 10'h1FF;
  localparam logic [9:0] xram_top_768  = 10'h2FF;
  localparam logic [9:0] xram_top_1024 = 10'h3FF;

endpackage

// File: core/aux_control_emi_ale.sv
`timescale 1ns/1ps
`default_nettype none

module aux_control_emi_ale (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Core status
  input  wire logic       double_speed_mode,
  input  wire logic       ext_access,
  input  wire logic       data_move_req,
  input  wire logic [9:0] data_move_addr,
  // Strobe pin, enable low while driven
  output logic            ale_out,
  output logic            ale_oe_n,
  output logic            ale_pullup,
  // Read/write strobe length and routing
  output logic      [2:0] rdwr_pulse_len,
  output logic            move_internal,
  output logic            move_external,
  output logic            pullup_disable
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // The strobe is one clock high per period, so a period needs two clocks
  if (aux_control_pkg::ale_div_x1 < 3'h2) begin : g_chk_div_x1
    $error("Normal strobe period below two clocks");
  end
  if (aux_control_pkg::ale_div_x2 < 3'h2) begin : g_chk_div_x2
    $error("Double-speed strobe period below two clocks");
  end
  // Double speed must never slow the strobe down
  if (aux_control_pkg::ale_div_x2 > aux_control_pkg::ale_div_x1) begin : g_chk_div_order
    $error("Double-speed strobe period longer than normal");
  end
  if (aux_control_pkg::rdwr_len_long == 3'h0) begin : g_chk_len_long
    $error("Stretched read/write strobe length of zero");
  end
  if (aux_control_pkg::rdwr_len_short == 3'h0) begin : g_chk_len_short
    $error("Short read/write strobe length of zero");
  end
  // A reset value with reserved bits set could never be read back
  if ((aux_control_pkg::aux_control_reset & ~aux_control_pkg::aux_control_wmask) != 8'h00)
  begin : g_chk_reset
    $error("Reset value sets reserved register bits");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] aux;
    logic [7:0] rdata;
    logic [2:0] div_cnt;
    logic       ale;
    logic       ale_oe_n;
    logic       ale_pu;
    logic [2:0] rdwr_len;
    logic       mv_int;
    logic       mv_ext;
    logic       pu_dis;
  } state_t;

  state_t     s_q;
  state_t     s_d;
  logic       wr_hit;
  logic       rd_hit;
  logic [2:0] div_lim;
  logic       div_wrap;
  logic       free_run;
  logic       drive_pin;
  logic [1:0] size_sel;
  logic [9:0] xram_top;
  logic       in_window;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d       = s_q;
    wr_hit    = 1'b0;
    rd_hit    = 1'b0;
    div_lim   = aux_control_pkg::ale_div_x1;
    div_wrap  = 1'b0;
    free_run  = 1'b0;
    drive_pin = 1'b0;
    size_sel  = 2'b11;
    xram_top  = aux_control_pkg::xram_top_1024;
    in_window = 1'b0;

    // ****************************************************************
    // Register decode
    // ****************************************************************
    // Only the one mapped address answers; everything else is ignored
    wr_hit = reg_wr && (reg_addr == aux_control_pkg::aux_control_off);
    rd_hit = reg_rd && (reg_addr == aux_control_pkg::aux_control_off);

    // ****************************************************************
    // Register write
    // ****************************************************************
    // Reserved bits 6 and 4 are never stored, so stray software writes
    // cannot leave them set
    if (wr_hit) begin
      s_d.aux = reg_wdata & aux_control_pkg::aux_control_wmask;
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Read data stands one cycle after the strobe; unmapped reads zero
    s_d.rdata = 8'h00;
    if (rd_hit) begin
      // Reserved bits 6 and 4 read as zero
      s_d.rdata = s_q.aux & aux_control_pkg::aux_control_wmask;
    end

    // ****************************************************************
    // Strobe period counter
    // ****************************************************************
    // The counter free-runs even while the strobe is suppressed, so an
    // external access that starts later still sees the regular phase
    if (double_speed_mode) begin
      div_lim = aux_control_pkg::ale_div_x2;
    end else begin
      div_lim = aux_control_pkg::ale_div_x1;
    end
    // Greater-or-equal catches a count left high by a mode switch
    div_wrap = (s_q.div_cnt >= div_lim - 3'h1);
    if (div_wrap) begin
      s_d.div_cnt = 3'h0;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 3'h1;
    end

    // ****************************************************************
    // Strobe pin
    // ****************************************************************
    free_run  = !s_q.aux[aux_control_pkg::strobe_suppress_bit];
    drive_pin = free_run || ext_access;
    if (drive_pin) begin
      // One pulse per period at count zero
      s_d.ale      = (s_q.div_cnt == 3'h0);
      s_d.ale_oe_n = 1'b0;
      s_d.ale_pu   = 1'b0;
    end else begin
      // Released pin is held high by the pull-up only
      s_d.ale      = 1'b0;
      s_d.ale_oe_n = 1'b1;
      s_d.ale_pu   = 1'b1;
    end

    // ****************************************************************
    // Read/write strobe length
    // ****************************************************************
    if (s_q.aux[aux_control_pkg::strobe_stretch_select_bit]) begin
      s_d.rdwr_len = aux_control_pkg::rdwr_len_short;
    end else begin
      s_d.rdwr_len = aux_control_pkg::rdwr_len_long;
    end

    // ****************************************************************
    // Expanded RAM window
    // ****************************************************************
    size_sel = {s_q.aux[aux_control_pkg::xram_size_hi_bit],
                s_q.aux[aux_control_pkg::xram_size_lo_bit]};
    case (size_sel)
      2'b00: begin
        xram_top = aux_control_pkg::xram_top_256;
      end
      2'b01: begin
        xram_top = aux_control_pkg::xram_top_512;
      end
      2'b10: begin
        xram_top = aux_control_pkg::xram_top_768;
      end
      default: begin
        xram_top = aux_control_pkg::xram_top_1024;
      end
    endcase
    in_window = (data_move_addr <= xram_top);

    // ****************************************************************
    // Data move routing
    // ****************************************************************
    // Addresses past the selected size fall through to the external bus,
    // so a small window never swallows an access silently
    s_d.mv_int = data_move_req
                 && !s_q.aux[aux_control_pkg::external_data_select_bit]
                 && in_window;
    s_d.mv_ext = data_move_req && !s_d.mv_int;

    // ****************************************************************
    // Port pull-ups
    // ****************************************************************
    s_d.pu_dis = s_q.aux[aux_control_pkg::pullup_disable_bit];

    // ****************************************************************
    // Reset
    // ****************************************************************
    // Synchronous reset overrides everything above
    if (rst) begin
      s_d          = '0;
      s_d.aux      = aux_control_pkg::aux_control_reset;
      s_d.ale_oe_n = 1'b0;
      s_d.rdwr_len = aux_control_pkg::rdwr_len_long;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk) begin
    s_q <= s_d;
  end

  // ****************************************************************
  // Outputs, all straight from the state register
  // ****************************************************************
  assign reg_rdata      = s_q.rdata;
  assign ale_out        = s_q.ale;
  assign ale_oe_n       = s_q.ale_oe_n;
  assign ale_pullup     = s_q.ale_pu;
  assign rdwr_pulse_len = s_q.rdwr_len;
  assign move_internal  = s_q.mv_int;
  assign move_external  = s_q.mv_ext;
  assign pullup_disable = s_q.pu_dis;

endmodule

`default_nettype wire

// File: sim/ext_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic move_external,
  output logic      ext_access
);
  logic [2:0] busy_q;
  // Slow memory holds the bus for several cycles on each access
  always_ff @(posedge mclk) begin
    if (rst) busy_q <= 3'h0;
    else if (move_external) busy_q <= 3'h5;
    else if (busy_q != 3'h0) busy_q <= busy_q - 3'h1;
  end
  assign ext_access = busy_q != 3'h0;
endmodule
`default_nettype wire

// File: sim/aux_control_emi_ale_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module aux_control_emi_ale_assertions (
  input wire logic       mclk, rst, reg_wr, reg_rd, double_speed_mode, ext_access, data_move_req,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic [9:0] data_move_addr,
  input wire logic [2:0] rdwr_pulse_len,
  input wire logic       ale_out, ale_oe_n, ale_pullup, move_internal, move_external, pullup_disable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_wr;
    reg_wr && reg_addr == 8'h8E ##1 !(reg_wr && reg_addr == 8'h8E);
  endsequence
  a_oe_pullup: assert property (ale_oe_n |-> ale_pullup) else $error("undriven strobe lacks pull");
  a_ext_drive: assert property (ext_access [*2] |-> !ale_oe_n) else $error("strobe not driven");
  a_ale_x1: assert property (ale_out && !double_speed_mode |=> !ale_out [*5]) else $error("period");
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray data");
  a_rd_unmapped: assert property (reg_rd && reg_addr != 8'h8E |=> reg_rdata == 8'h00) else $error("unmapped");
  a_pullup_bit: assert property (s_wr |=> pullup_disable == $past(reg_wdata[7], 2)) else $error("pull bit");
  a_len_bit: assert property (s_wr |=> rdwr_pulse_len == ($past(reg_wdata[5], 2) ? 3'h3 : 3'h6)) else $error("len");
  a_move_one: assert property ($past(data_move_req) |-> move_internal != move_external) else $error("route");
  a_reset_val: assert property (disable iff (1'b0) rst |=> rdwr_pulse_len == 3'h6 && !pullup_disable)
    else $error("reset value");
endmodule
bind aux_control_emi_ale aux_control_emi_ale_assertions i_aux_control_emi_ale_assertions (.*);
`default_nettype wire

// File: sim/tb_aux_control_emi_ale.sv
`timescale 1ns/1ps
`default_nettype none
module tb_aux_control_emi_ale;
  logic       mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_p = 1'b0;
  logic       double_speed_mode = 1'b0, data_move_req = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v, n;
  logic [9:0] data_move_addr = 10'h000, top;
  logic [2:0] rdwr_pulse_len;
  logic       ext_access, ale_out, ale_oe_n, ale_pullup, move_internal, move_external, pullup_disable;
  logic [7:0] exp_q [$];
  int         fail_count = 0, check_count = 0;
  aux_control_emi_ale i_aux_control_emi_ale (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .double_speed_mode(double_speed_mode),
    .ext_access(ext_access), .data_move_req(data_move_req), .data_move_addr(data_move_addr),
    .ale_out(ale_out), .ale_oe_n(ale_oe_n), .ale_pullup(ale_pullup),
    .rdwr_pulse_len(rdwr_pulse_len), .move_internal(move_internal),
    .move_external(move_external), .pullup_disable(pullup_disable));
  ext_mem_model i_ext_mem_model (.mclk(mclk), .rst(rst), .move_external(move_external),
    .ext_access(ext_access));
  initial forever #2.5 mclk = ~mclk;
  task chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; @(posedge mclk); reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  // Each access ends one edge after lowering its strobe, so no strobe is set twice at once
  task rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a; reg_rd <= 1'b1; exp_q.push_back(e); @(posedge mclk); reg_rd <= 1'b0;
    @(posedge mclk);
  endtask
  task wrap_up;
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    if (rd_p) chk(reg_rdata, exp_q.pop_front());
    rd_p <= reg_rd;
  end
  task count_ale(input logic [7:0] e);
    repeat (12) @(posedge mclk);
    n = 8'h00;
    repeat (60) begin @(posedge mclk); n += {7'h00, ale_out}; end
    chk(n, e);
  endtask
  initial begin
    void'($urandom(89));
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(8'h8E, 8'h0C); @(posedge mclk);
    chk({5'h00, rdwr_pulse_len}, 8'h06);
    for (int i = 0; i < 40; i++) begin
      v = 8'($urandom) & 8'hAF; data_move_addr <= 10'($urandom); top = {v[3:2], 8'hFF};
      wr(8'h8E, v); wr(8'h8F, ~v); rd(8'h8E, v & 8'hAF); @(posedge mclk); rd(8'h8F, 8'h00);
      data_move_req <= 1'b1; @(posedge mclk); data_move_req <= 1'b0; #1;
      chk({7'h00, move_internal}, {7'h00, !v[1] && data_move_addr <= top});
      chk({7'h00, move_external}, {7'h00, v[1] || data_move_addr > top});
      chk({7'h00, pullup_disable}, {7'h00, v[7]});
      chk({5'h00, rdwr_pulse_len}, v[5] ? 8'h03 : 8'h06);
      repeat (8) @(posedge mclk);
    end
    wr(8'h8E, 8'h00); count_ale(8'h0A);
    wr(8'h8E, 8'h01); repeat (3) @(posedge mclk);
    chk({6'h00, ale_oe_n, ale_pullup}, 8'h03);
    wr(8'h8E, 8'h03); data_move_req <= 1'b1; @(posedge mclk); data_move_req <= 1'b0;
    repeat (3) @(posedge mclk); #1;
    chk({6'h00, ale_oe_n, ale_pullup}, 8'h00);
    @(posedge mclk);
    double_speed_mode <= 1'b1; wr(8'h8E, 8'h00); count_ale(8'h14);
    wrap_up;
  end
endmodule
`default_nettype wire
